// ---- rba_map.vh ----
// Constants for the rebuild assist read error reporting block
`ifndef RBA_MAP_VH
`define RBA_MAP_VH
// Register offsets of the plain register port
`define RBA_REG_CTRL 8'h00
`define RBA_REG_STATUS 8'h04
`define RBA_REG_LOG_ADDR 8'h08
`define RBA_REG_LOG_DATA 8'h0C
`define RBA_REG_ERR_SENSE 8'h10
`define RBA_REG_ERR_LBA 8'h14
`define RBA_REG_ERR_FINAL 8'h18
`define RBA_REG_IDENT 8'h1C
// Control fields
`define RBA_CTRL_EN_BIT 0
`define RBA_CTRL_RESET 32'h00000000
// Log page
`define RBA_LOG_PAGE 8'h15
`define RBA_LOG_BYTES 512
`define RBA_LOG_LEN_BYTE 9'h007
`define RBA_LOG_MASK_BYTE 9'h008
`define RBA_ELEM_LEN 8'h02
`define RBA_ELEM_MASK 16'h00FF
`define RBA_ELEM_BITS 16
// Identify data support bit
`define RBA_IDENT_WORD 8'd78
`define RBA_IDENT_BIT 11
// Queued error log values
`define RBA_SENSE_KEY 4'hB
`define RBA_ASC_ASCQ 16'h1103
`endif

// ---- rba_log_mem.v ----
// Byte-wide log page memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module rba_log_mem
(
  input wire core_clk,
  input wire we,
  input wire [8:0] waddr,
  input wire [7:0] wdata,
  input wire [8:0] raddr,
  output reg [7:0] rdata
);
  reg [7:0] mem [0:511];

  // Write port and registered read
  always @(posedge core_clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // rba_log_mem
`default_nettype wire

// ---- rba_core.v ----
// Rebuild assist: queued read error reporting and rebuild assist log
//
// Operation
// [RL1] Host should pull data with consecutive queued reads when the feature is on.
// [RL2] A read with no unrecovered error completes without error.
// [RL3] A read with bypass flag set is processed as if the feature were absent.
// [RL4] Predicted error with bypass clear logs sense key Bh.
// [RL5] Predicted error logs additional sense code and qualifier 1103h.
// [RL6] Logged LBA is the first unrecovered sector of the read.
// [RL7] Final LBA is the last sector of the contiguous failing run.
// [RL8] Support bit in identify word 78 bit 11 means log 15h exists.
// [RL9] Log: byte 7 length N, mask N bytes, disabled bits N bytes, rest reserved.
// [RL10] Host writes to length and mask fields are ignored.
// [RL11] Mask bits mark which disabled-element bits are implemented.
// [RL12] Disabled element bit one makes its LBAs report predicted errors.
// [RL13] Disabled element bit zero leaves its LBAs without predicted errors.
// [RL14] Byte 0 bit of the log shows the feature enable state.
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "rba_map.vh"
module rba_core
(
  input wire core_clk,
  input wire nrst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Queued read request, one cycle
  input wire rd_start,
  input wire [47:0] rd_lba,
  input wire [15:0] rd_count,
  input wire rebuild_bypass_flag,
  // Media check of one sector per cycle, answered same cycle
  output reg sec_req,
  output reg [47:0] sec_lba,
  input wire sec_unrec,
  input wire sec_predicted,
  input wire [3:0] sec_elem,
  // Completion
  output reg rd_done,
  output reg rd_error,
  output reg rd_busy,
  output reg ident_rebuild_sup
);
  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_SCAN = 2'b01;
  localparam ST_RUN = 2'b10;
  localparam ST_DONE = 2'b11;

  reg [1:0] state_q;
  reg enable_q;
  reg [8:0] log_addr_q;
  reg [15:0] disabled_q;
  reg [47:0] cur_lba_q;
  reg [15:0] left_q;
  reg bypass_q;
  reg err_q;
  reg [3:0] sense_key_q;
  reg [15:0] asc_q;
  reg [47:0] err_lba_q;
  reg [47:0] final_lba_q;
  reg mem_we;
  reg [8:0] mem_waddr;
  reg [7:0] mem_wdata;
  wire [7:0] mem_rdata;
  reg [31:0] rd_word;
  // Fixed support mask as a vector so single bits and bytes can be picked
  wire [15:0] elem_mask = `RBA_ELEM_MASK;

  // Backing store for the reserved tail of the log page
  rba_log_mem u_mem
  (
    .core_clk(core_clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(log_addr_q),
    .rdata(mem_rdata)
  );

  // ------------------------------------------------------------
  // Element lookup
  // ------------------------------------------------------------
  // Only implemented elements can force an error
  wire elem_disabled = disabled_q[sec_elem] & elem_mask[sec_elem]; // see [RL11]
  // Feature acts only when enabled and not bypassed
  wire assist_on = enable_q & ~bypass_q; // see [RL3]
  // Sector counts as a predicted failure
  wire sec_pred_err = sec_predicted | elem_disabled; // see [RL12]
  wire sec_bad = assist_on ? (sec_unrec | sec_pred_err) : sec_unrec; // see [RL13]

  // ------------------------------------------------------------
  // Log byte view
  // ------------------------------------------------------------
  // Byte layout of the log page
  function [7:0] log_byte;
    input [8:0] a;
    input [7:0] mem_b;
    begin
      if (a == 9'h000)
        log_byte = {7'h00, enable_q}; // see [RL14]
      else if (a == `RBA_LOG_LEN_BYTE)
        log_byte = `RBA_ELEM_LEN; // see [RL9]
      else if (a == 9'h008)
        log_byte = elem_mask[15:8];
      else if (a == 9'h009)
        log_byte = elem_mask[7:0];
      else if (a == 9'h00A)
        log_byte = disabled_q[15:8];
      else if (a == 9'h00B)
        log_byte = disabled_q[7:0];
      else
        log_byte = 8'h00;
    end
  endfunction

  // Read data mux for the register port
  always @*
  begin
    case (reg_addr)
      `RBA_REG_CTRL: rd_word = {31'h00000000, enable_q};
      `RBA_REG_STATUS: rd_word = {28'h0000000, err_q, bypass_q, state_q};
      `RBA_REG_LOG_ADDR: rd_word = {23'h000000, log_addr_q};
      `RBA_REG_LOG_DATA: rd_word = {24'h000000, log_byte(log_addr_q, mem_rdata)};
      `RBA_REG_ERR_SENSE: rd_word = {12'h000, sense_key_q, asc_q};
      `RBA_REG_ERR_LBA: rd_word = err_lba_q[31:0];
      `RBA_REG_ERR_FINAL: rd_word = final_lba_q[31:0];
      `RBA_REG_IDENT: rd_word = {16'h0000, err_lba_q[47:32]};
      default: rd_word = 32'h00000000;
    endcase
  end

  // Log write decode: length and mask stay fixed
  always @*
  begin
    mem_we = 1'b0;
    mem_waddr = log_addr_q;
    mem_wdata = reg_wdata[7:0];
    if (reg_wr && reg_addr == `RBA_REG_LOG_DATA && log_addr_q > 9'h00B)
      mem_we = 1'b1; // see [RL10]
  end

  // ------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      enable_q <= 1'b0;
      log_addr_q <= 9'h000;
      disabled_q <= 16'h0000;
      reg_rdata <= 32'h00000000;
      ident_rebuild_sup <= 1'b0;
    end
    else
    begin
      ident_rebuild_sup <= 1'b1; // see [RL8]
      // Read data stand only in the cycle after the read strobe
      reg_rdata <= reg_rd ? rd_word : 32'h00000000;
      if (reg_wr)
      begin
        case (reg_addr)
          `RBA_REG_CTRL: enable_q <= reg_wdata[`RBA_CTRL_EN_BIT];
          `RBA_REG_LOG_ADDR: log_addr_q <= reg_wdata[8:0];
          `RBA_REG_LOG_DATA:
          begin
            if (log_addr_q == 9'h000)
              enable_q <= reg_wdata[0]; // see [RL14]
            else if (log_addr_q == 9'h00A)
              disabled_q[15:8] <= reg_wdata[7:0] & elem_mask[15:8]; // see [RL11]
            else if (log_addr_q == 9'h00B)
              disabled_q[7:0] <= reg_wdata[7:0] & elem_mask[7:0]; // see [RL11]
          end
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Queued read walker
  // ------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      state_q <= ST_IDLE;
      cur_lba_q <= 48'h000000000000;
      left_q <= 16'h0000;
      bypass_q <= 1'b0;
      err_q <= 1'b0;
      sense_key_q <= 4'h0;
      asc_q <= 16'h0000;
      err_lba_q <= 48'h000000000000;
      final_lba_q <= 48'h000000000000;
      sec_req <= 1'b0;
      sec_lba <= 48'h000000000000;
      rd_done <= 1'b0;
      rd_error <= 1'b0;
      rd_busy <= 1'b0;
    end
    else
    begin
      rd_done <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (rd_start && rd_count != 16'h0000)
          begin
            bypass_q <= rebuild_bypass_flag; // see [RL3]
            err_q <= 1'b0;
            cur_lba_q <= rd_lba;
            sec_lba <= rd_lba;
            left_q <= rd_count;
            sec_req <= 1'b1;
            rd_busy <= 1'b1;
            state_q <= ST_SCAN;
          end
        end
        ST_SCAN:
        begin
          // One sector checked per cycle
          if (sec_bad)
          begin
            err_q <= 1'b1;
            if (assist_on && sec_pred_err)
            begin
              sense_key_q <= `RBA_SENSE_KEY; // see [RL4]
              asc_q <= `RBA_ASC_ASCQ; // see [RL5]
              err_lba_q <= cur_lba_q; // see [RL6]
              final_lba_q <= cur_lba_q;
              state_q <= ST_RUN;
              cur_lba_q <= cur_lba_q + 48'h000000000001;
              sec_lba <= cur_lba_q + 48'h000000000001;
            end
            else
            begin
              err_lba_q <= cur_lba_q;
              final_lba_q <= cur_lba_q;
              sec_req <= 1'b0;
              state_q <= ST_DONE;
            end
          end
          else if (left_q == 16'h0001)
          begin
            sec_req <= 1'b0;
            state_q <= ST_DONE; // see [RL2]
          end
          else
          begin
            left_q <= left_q - 16'h0001;
            cur_lba_q <= cur_lba_q + 48'h000000000001;
            sec_lba <= cur_lba_q + 48'h000000000001;
          end
        end
        ST_RUN:
        begin
          // Extend the failing run past the read's own end
          if (sec_unrec || sec_pred_err)
          begin
            final_lba_q <= cur_lba_q; // see [RL7]
            cur_lba_q <= cur_lba_q + 48'h000000000001;
            sec_lba <= cur_lba_q + 48'h000000000001;
          end
          else
          begin
            sec_req <= 1'b0;
            state_q <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          rd_done <= 1'b1;
          rd_error <= err_q; // see [RL2]
          rd_busy <= 1'b0;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // rba_core
`default_nettype wire

// ---- rba_core_sva.sv ----
// Checker on the rebuild assist core ports
`timescale 1ns/1ns
`default_nettype none
module rba_core_sva
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic rd_start,
  input wire logic [47:0] rd_lba,
  input wire logic [15:0] rd_count,
  input wire logic rebuild_bypass_flag,
  input wire logic sec_req,
  input wire logic [47:0] sec_lba,
  input wire logic sec_unrec,
  input wire logic sec_predicted,
  input wire logic rd_done,
  input wire logic rd_error,
  input wire logic rd_busy,
  input wire logic ident_rebuild_sup
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic byp_q;
  logic bad_q;
  // Track bypass of the read and whether any sector looked bad
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      byp_q <= 1'b0;
      bad_q <= 1'b0;
    end
    else if (rd_start && !rd_busy)
    begin
      byp_q <= rebuild_bypass_flag;
      bad_q <= 1'b0;
    end
    else if (sec_req && (sec_unrec || sec_predicted))
      bad_q <= 1'b1;
  end
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  AST_IDENT_SET: assert property ($past(nrst, 2) |-> ident_rebuild_sup)
    else $error("support bit low");
  AST_START_LBA: assert property (rd_start && !rd_busy && rd_count != 16'h0
    |=> sec_req && sec_lba == $past(rd_lba)) else $error("first sector wrong");
  AST_LBA_STEP: assert property (sec_req && $past(sec_req)
    |-> sec_lba == $past(sec_lba) + 48'h1) else $error("sector not sequential");
  AST_DONE_AFTER: assert property ($fell(sec_req) |=> rd_done)
    else $error("no completion after last sector");
  AST_DONE_PULSE: assert property (rd_done |=> !rd_done)
    else $error("completion longer than one cycle");
  AST_REQ_BUSY: assert property (sec_req |-> rd_busy)
    else $error("sector check while idle");
  AST_GOOD_READ: assert property (rd_done && byp_q && !bad_q |-> !rd_error)
    else $error("bypass read failed without bad sector");
endmodule // rba_core_sva
`default_nettype wire

// ---- rba_media_model.sv ----
// Media side model answering sector checks
`timescale 1ns/1ns
`default_nettype none
module rba_media_model
(
  input wire logic core_clk,
  input wire logic sec_req,
  input wire logic [47:0] sec_lba,
  input wire logic [47:0] pred_lo,
  input wire logic [47:0] pred_hi,
  output logic sec_unrec,
  output logic sec_predicted,
  output logic [3:0] sec_elem
);
  logic tog_q = 1'b0;
  // Idle pattern so stale answers are never trusted
  always @(posedge core_clk)
    tog_q <= !tog_q;
  // Same cycle answer; element is the low LBA nibble
  always_comb
  begin
    sec_unrec = sec_req ? 1'b0 : tog_q;
    sec_predicted = sec_req ? (sec_lba >= pred_lo && sec_lba <= pred_hi) : tog_q;
    sec_elem = sec_req ? sec_lba[3:0] : {4{tog_q}};
  end
endmodule // rba_media_model
`default_nettype wire

// ---- rba_core_bench.sv ----
// Testbench for the rebuild assist core
`timescale 1ns/1ns
`default_nettype none
`include "rba_map.vh"
module rba_core_bench;
  logic core_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic rd_start = 1'b0, rebuild_bypass_flag = 1'b0;
  logic [47:0] rd_lba = 48'h0, sec_lba;
  logic [15:0] rd_count = 16'h0;
  logic sec_req, sec_unrec, sec_predicted, rd_done, rd_error, rd_busy, ident_rebuild_sup;
  logic [3:0] sec_elem;
  int bad_count = 0, n_compared = 0, i;
  always #10 core_clk = !core_clk;
  rba_core u_dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rd_start(rd_start), .rd_lba(rd_lba), .rd_count(rd_count),
    .rebuild_bypass_flag(rebuild_bypass_flag), .sec_req(sec_req), .sec_lba(sec_lba),
    .sec_unrec(sec_unrec), .sec_predicted(sec_predicted), .sec_elem(sec_elem),
    .rd_done(rd_done), .rd_error(rd_error), .rd_busy(rd_busy),
    .ident_rebuild_sup(ident_rebuild_sup));
  rba_media_model u_media (.core_clk(core_clk), .sec_req(sec_req), .sec_lba(sec_lba),
    .pred_lo(48'h102), .pred_hi(48'h104), .sec_unrec(sec_unrec),
    .sec_predicted(sec_predicted), .sec_elem(sec_elem));
  // Compare one value and count it
  task chk(input string n, input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rreg(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task logb(input logic [7:0] a, input logic [7:0] e);
    wreg(`RBA_REG_LOG_ADDR, {24'h0, a});
    rreg(`RBA_REG_LOG_DATA);
    chk("log byte", {40'h0, d[7:0]}, {40'h0, e});
  endtask
  task logw(input logic [7:0] a, input logic [7:0] v);
    wreg(`RBA_REG_LOG_ADDR, {24'h0, a});
    wreg(`RBA_REG_LOG_DATA, {24'h0, v});
  endtask
  // Start one queued read and wait for its completion
  task rdop(input logic [47:0] l, input logic [15:0] c, input logic b, input logic e);
    @(posedge core_clk);
    rd_lba <= l;
    rd_count <= c;
    rebuild_bypass_flag <= b;
    rd_start <= 1'b1;
    @(posedge core_clk);
    rd_start <= 1'b0;
    for (i = 0; i < 200 && rd_done !== 1'b1; i++)
      @(posedge core_clk) #1;
    chk("done", {47'h0, rd_done}, 48'h1);
    chk("rd_error", {47'h0, rd_error}, {47'h0, e});
  endtask
  task t_fixed;
    chk("ident", {47'h0, ident_rebuild_sup}, 48'h1);
    logb(8'h07, `RBA_ELEM_LEN);
    logb(8'h08, 8'h00);
    logb(8'h09, 8'hFF);
    logw(8'h07, 8'h55);
    logw(8'h09, 8'h00);
    logb(8'h07, `RBA_ELEM_LEN);
    logb(8'h09, 8'hFF);
    rreg(8'h3C);
    chk("unmapped", {16'h0, d}, 48'h0);
  endtask
  task t_pred;
    wreg(`RBA_REG_CTRL, 32'h1);
    logb(8'h00, 8'h01);
    rdop(48'h200, 16'h4, 1'b0, 1'b0);
    rdop(48'h204, 16'h4, 1'b1, 1'b0);
    rdop(48'h100, 16'h8, 1'b0, 1'b1);
    rreg(`RBA_REG_ERR_SENSE);
    chk("sense", {16'h0, d}, {28'h0, `RBA_SENSE_KEY, `RBA_ASC_ASCQ});
    rreg(`RBA_REG_ERR_LBA);
    chk("err lba", {16'h0, d}, 48'h102);
    rreg(`RBA_REG_ERR_FINAL);
    chk("final lba", {16'h0, d}, 48'h104);
    rdop(48'h100, 16'h8, 1'b1, 1'b0);
  endtask
  task t_elem;
    logw(8'h0B, 8'h20);
    logb(8'h0B, 8'h20);
    rdop(48'h130, 16'h8, 1'b0, 1'b1);
    rreg(`RBA_REG_ERR_LBA);
    chk("elem lba", {16'h0, d}, 48'h135);
    rreg(`RBA_REG_ERR_FINAL);
    chk("elem final", {16'h0, d}, 48'h135);
    logw(8'h0B, 8'h00);
    rdop(48'h130, 16'h8, 1'b0, 1'b0);
  endtask
  task stop_test;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_fixed;
    t_pred;
    t_elem;
    stop_test;
  end
  initial
  begin
    #200000;
    bad_count++;
    stop_test;
  end
endmodule // rba_core_bench
bind rba_core rba_core_sva u_sva (.core_clk(core_clk), .nrst(nrst), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rd_start(rd_start), .rd_lba(rd_lba), .rd_count(rd_count),
  .rebuild_bypass_flag(rebuild_bypass_flag), .sec_req(sec_req), .sec_lba(sec_lba),
  .sec_unrec(sec_unrec), .sec_predicted(sec_predicted), .rd_done(rd_done),
  .rd_error(rd_error), .rd_busy(rd_busy), .ident_rebuild_sup(ident_rebuild_sup));
`default_nettype wire
